/* File: rtl/exsb_bank.sv */
// Read-only exception status bank answering acyclic record reads.
// Assumes a record-request front end that decodes frames into strobes.
//
// What this block does
// - Summary word derives continuously from detail words.
// - Summary bit is 1 while category active, 0 otherwise.
// - Summary bit 0 set when global device warning word nonzero.
// - Summary bit 1 set when vendor or global vendor warning nonzero.
// - Summary bit 2 set when global device error word nonzero.
// - Summary bit 3 set when vendor or global vendor error nonzero.
// - Global warning bit 1 on disturbed link or sensor mismatch.
// - Global warning and error bit 3 on nonvolatile memory exception.
// - Global vendor error bits 1,2,3: timeout, checksum, record error.
// - Global vendor error bits 5,9,10,11: configuration faults.
// - Vendor warning bit 8 while atmospheric sensor out of range.
// - Vendor error bit 4 broken filament, bit 6 broken diaphragm.
// - Global vendor warning word is reserved and reads zero.
`include "exsb_regs.svh"

module exsb_bank (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // Record request port
  input  wire logic        rec_req_i,
  input  wire logic        rec_wr_i,
  input  wire logic [15:0] rec_slot_i,
  input  wire logic [15:0] rec_subslot_i,
  input  wire logic [15:0] rec_index_i,
  output logic             rec_ack_o,
  output logic             rec_err_o,
  output logic [31:0]      rec_rdata_o,
  // Fault conditions from the sensor logic
  input  wire logic        comm_disturbed_i,
  input  wire logic        sensor_mismatch_i,
  input  wire logic        nonvolatile_flag_i,
  input  wire logic        nvm_timeout_i,
  input  wire logic        checksum_err_i,
  input  wire logic        record_err_i,
  input  wire logic        filament_material_i,
  input  wire logic        atmospheric_pressure_sensor_cfg_i,
  input  wire logic        insulation_config_i,
  input  wire logic        board_config_i,
  input  wire logic        atmospheric_pressure_sensor_range_i,
  input  wire logic        filament_broken_i,
  input  wire logic        diaphragm_broken_i,
  // Summary exposed for local indicators
  output logic [7:0]       summary_o
);

  // ----------------------------------------------------------------
  // Detail words
  // ----------------------------------------------------------------
  logic [31:0] glb_warn_w;
  logic [31:0] glb_err_w;
  logic [31:0] gv_err_w;
  logic [31:0] v_warn_w;
  logic [31:0] v_err_w;
  logic [31:0] gv_warn_w;
  logic [7:0]  summary_w;

  // Global device warning: link/fit and memory exception
  exsb_detail_word #(.NUM(2)) u_glb_warn (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .fault_i   ({nonvolatile_flag_i, comm_disturbed_i | sensor_mismatch_i}),
    .pos_i     ({5'(`EXSB_GLB_NVM_EXC), 5'(`EXSB_GLB_COMM_FIT)}),
    .word_o    (glb_warn_w)
  );

  // Global device error mirrors the warning layout
  exsb_detail_word #(.NUM(2)) u_glb_err (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .fault_i   ({nonvolatile_flag_i, comm_disturbed_i | sensor_mismatch_i}),
    .pos_i     ({5'(`EXSB_GLB_NVM_EXC), 5'(`EXSB_GLB_COMM_FIT)}),
    .word_o    (glb_err_w)
  );

  // Global vendor error: memory and configuration faults
  exsb_detail_word #(.NUM(7)) u_gv_err (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .fault_i   ({board_config_i, insulation_config_i, atmospheric_pressure_sensor_cfg_i,
                 filament_material_i, record_err_i, checksum_err_i,
                 nvm_timeout_i}),
    .pos_i     ({5'(`EXSB_GVE_BOARD_CFG), 5'(`EXSB_GVE_INSUL_CFG),
                 5'(`EXSB_GVE_APS_CFG), 5'(`EXSB_GVE_FILAMENT_MAT),
                 5'(`EXSB_GVE_RECORD), 5'(`EXSB_GVE_CHECKSUM),
                 5'(`EXSB_GVE_NVM_TIMEOUT)}),
    .word_o    (gv_err_w)
  );

  // Vendor warning: atmospheric sensor range
  exsb_detail_word #(.NUM(1)) u_v_warn (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .fault_i   (atmospheric_pressure_sensor_range_i),
    .pos_i     (5'(`EXSB_VW_APS_RANGE)),
    .word_o    (v_warn_w)
  );

  // Vendor error: broken sensing elements
  exsb_detail_word #(.NUM(2)) u_v_err (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .fault_i   ({diaphragm_broken_i, filament_broken_i}),
    .pos_i     ({5'(`EXSB_VE_DIAPHRAGM_BROKEN), 5'(`EXSB_VE_FILAMENT_BROKEN)}),
    .word_o    (v_err_w)
  );

  // Reserved word, tied so no future source can leak in
  assign gv_warn_w = `EXSB_WORD_RESET;

  // ----------------------------------------------------------------
  // Summary
  // ----------------------------------------------------------------
  // Follows the detail registers in the same cycle
  exsb_summary u_summary (
    .global_warning_i        (glb_warn_w),
    .vendor_warning_i        (v_warn_w),
    .global_vendor_warning_i (gv_warn_w),
    .global_error_i          (glb_err_w),
    .vendor_error_i          (v_err_w),
    .global_vendor_error_i   (gv_err_w),
    .summary_o               (summary_w)
  );

  assign summary_o = summary_w;

  // ----------------------------------------------------------------
  // Record decode
  // ----------------------------------------------------------------
  // Only slot 0, subslot 10 belongs to this bank
  wire addr_here = (rec_slot_i == `EXSB_SLOT) &&
                   (rec_subslot_i == `EXSB_SUBSLOT);

  logic        hit;
  logic [31:0] sel_data;

  // Index select; misses flag an error answer
  always_comb begin
    hit      = 1'b1;
    sel_data = `EXSB_WORD_RESET;
    case (rec_index_i)
      `EXSB_IDX_EXCEPTION_SUMMARY:      sel_data = {24'h00_0000, summary_w};
      `EXSB_IDX_VENDOR_WARNING_DETAILS: sel_data = v_warn_w;
      `EXSB_IDX_VENDOR_ERROR_DETAILS:   sel_data = v_err_w;
      `EXSB_IDX_GLOBAL_WARNING_DETAILS: sel_data = glb_warn_w;
      `EXSB_IDX_GLOBAL_VENDOR_WARNING:  sel_data = gv_warn_w;
      `EXSB_IDX_GLOBAL_ERROR_DETAILS:   sel_data = glb_err_w;
      `EXSB_IDX_GLOBAL_VENDOR_ERROR:    sel_data = gv_err_w;
      default:                          hit = 1'b0;
    endcase
  end

  // Writes are refused outright: nothing here is writable or clearable
  wire good_rd = rec_req_i && !rec_wr_i && addr_here && hit;
  wire bad_req = rec_req_i && !good_rd;

  // ----------------------------------------------------------------
  // Answer state
  // ----------------------------------------------------------------
  exsb_pkg::exsb_rd_state_type state_r;
  exsb_pkg::exsb_rd_state_type state_nxt;
  logic [31:0]                 rdata_r;
  logic [31:0]                 rdata_nxt;

  // One answer cycle after each request, then back to idle unless another request arrives in that cycle
  always_comb begin
    state_nxt = exsb_pkg::EXSB_IDLE;
    rdata_nxt = rdata_r;
    case (state_r)
      exsb_pkg::EXSB_IDLE,
      exsb_pkg::EXSB_REPLY,
      exsb_pkg::EXSB_ERROR: begin
        if (good_rd) begin
          state_nxt = exsb_pkg::EXSB_REPLY;
          rdata_nxt = sel_data;
        end else if (bad_req) begin
          state_nxt = exsb_pkg::EXSB_ERROR;
          rdata_nxt = `EXSB_WORD_RESET;
        end
      end
      default: state_nxt = exsb_pkg::EXSB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= exsb_pkg::EXSB_IDLE;
      rdata_r <= `EXSB_WORD_RESET;
    end else begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rec_ack_o   = (state_r == exsb_pkg::EXSB_REPLY) ||
                       (state_r == exsb_pkg::EXSB_ERROR);
  assign rec_err_o   = (state_r == exsb_pkg::EXSB_ERROR);
  assign rec_rdata_o = rdata_r;

endmodule

/* File: rtl/exsb_detail_word.sv */
// One detail status word: places fault levels at their bit positions.
// Assumes fault inputs are synchronous to ref_clk_i.
`include "exsb_regs.svh"

module exsb_detail_word #(
  parameter int unsigned NUM = 4
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [NUM-1:0] fault_i,
  input  wire logic [NUM*5-1:0] pos_i,
  output logic [31:0]      word_o
);

  // ----------------------------------------------------------------
  // Placement
  // ----------------------------------------------------------------
  logic [31:0] word_nxt;
  logic [31:0] word_r;

  // Unlisted positions stay zero since only listed bits are ORed in
  always_comb begin
    word_nxt = `EXSB_WORD_RESET;
    for (int i = 0; i < NUM; i++) begin
      if (fault_i[i]) begin
        word_nxt[pos_i[i*5 +: 5]] = 1'b1;
      end
    end
  end

  // Registered so reads see a stable word
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_r <= `EXSB_WORD_RESET;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign word_o = word_r;

endmodule

/* File: rtl/exsb_pkg.sv */
// Types shared by the exception status bank.
// Assumes the register header is compiled alongside.
package exsb_pkg;

  // ----------------------------------------------------------------
  // Read port state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EXSB_IDLE  = 2'b00,
    EXSB_REPLY = 2'b01,
    EXSB_ERROR = 2'b10
  } exsb_rd_state_type;

  typedef logic [31:0] exsb_word_type;

endpackage

/* File: rtl/exsb_regs.svh */
// Offsets, field positions and widths of the exception status bank.
// Assumes inclusion by the bank and its helpers; definitions only.
`ifndef EXSB_REGS_SVH
`define EXSB_REGS_SVH

// ----------------------------------------------------------------
// Record indices (slot 0, subslot 10)
// ----------------------------------------------------------------
`define EXSB_SLOT                          16'h0000
`define EXSB_SUBSLOT                       16'h000a
`define EXSB_IDX_EXCEPTION_SUMMARY         16'h0040
`define EXSB_IDX_VENDOR_WARNING_DETAILS    16'h0042
`define EXSB_IDX_VENDOR_ERROR_DETAILS      16'h0044
`define EXSB_IDX_GLOBAL_WARNING_DETAILS    16'h0045
`define EXSB_IDX_GLOBAL_VENDOR_WARNING     16'h0046
`define EXSB_IDX_GLOBAL_ERROR_DETAILS      16'h0047
`define EXSB_IDX_GLOBAL_VENDOR_ERROR       16'h0048

// ----------------------------------------------------------------
// Summary bits
// ----------------------------------------------------------------
`define EXSB_SUM_DEV_WARN                  0
`define EXSB_SUM_VND_WARN                  1
`define EXSB_SUM_DEV_ERR                   2
`define EXSB_SUM_VND_ERR                   3

// ----------------------------------------------------------------
// Detail bit positions
// ----------------------------------------------------------------
`define EXSB_GLB_COMM_FIT                  1
`define EXSB_GLB_NVM_EXC                   3
`define EXSB_GVE_NVM_TIMEOUT               1
`define EXSB_GVE_CHECKSUM                  2
`define EXSB_GVE_RECORD                    3
`define EXSB_GVE_FILAMENT_MAT              5
`define EXSB_GVE_APS_CFG                   9
`define EXSB_GVE_INSUL_CFG                 10
`define EXSB_GVE_BOARD_CFG                 11
`define EXSB_VW_APS_RANGE                  8
`define EXSB_VE_FILAMENT_BROKEN            4
`define EXSB_VE_DIAPHRAGM_BROKEN           6

// Reset value of every status word
`define EXSB_WORD_RESET                    32'h0000_0000
`define EXSB_SUM_RESET                     8'h00

`endif

/* File: rtl/exsb_summary.sv */
// Consolidated summary: one flag per category from the detail words.
// Assumes detail words are registered in the same clock domain.
`include "exsb_regs.svh"

module exsb_summary (
  input  wire logic [31:0] global_warning_i,
  input  wire logic [31:0] vendor_warning_i,
  input  wire logic [31:0] global_vendor_warning_i,
  input  wire logic [31:0] global_error_i,
  input  wire logic [31:0] vendor_error_i,
  input  wire logic [31:0] global_vendor_error_i,
  output logic [7:0]       summary_o
);

  // ----------------------------------------------------------------
  // Category flags
  // ----------------------------------------------------------------
  wire dev_warn = |global_warning_i;
  wire vnd_warn = |vendor_warning_i | |global_vendor_warning_i;
  wire dev_err  = |global_error_i;
  wire vnd_err  = |vendor_error_i | |global_vendor_error_i;

  // Combinational so the summary never lags its detail words
  always_comb begin
    summary_o = `EXSB_SUM_RESET;
    summary_o[`EXSB_SUM_DEV_WARN] = dev_warn;
    summary_o[`EXSB_SUM_VND_WARN] = vnd_warn;
    summary_o[`EXSB_SUM_DEV_ERR]  = dev_err;
    summary_o[`EXSB_SUM_VND_ERR]  = vnd_err;
  end

endmodule

/* File: sim/exsb_bank_chk.sv */
// Port checker for the exception status bank.
// Assumes single clock domain; bound onto every bank instance.
module exsb_bank_chk (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        rec_req_i,
  input  wire logic        rec_wr_i,
  input  wire logic [15:0] rec_slot_i,
  input  wire logic [15:0] rec_subslot_i,
  input  wire logic [15:0] rec_index_i,
  input  wire logic        rec_ack_o,
  input  wire logic        rec_err_o,
  input  wire logic [31:0] rec_rdata_o,
  input  wire logic        comm_disturbed_i,
  input  wire logic        sensor_mismatch_i,
  input  wire logic        nonvolatile_flag_i,
  input  wire logic        atmospheric_pressure_sensor_range_i,
  input  wire logic        filament_broken_i,
  input  wire logic        diaphragm_broken_i,
  input  wire logic        nvm_timeout_i,
  input  wire logic        checksum_err_i,
  input  wire logic        record_err_i,
  input  wire logic        filament_material_i,
  input  wire logic        atmospheric_pressure_sensor_cfg_i,
  input  wire logic        insulation_config_i,
  input  wire logic        board_config_i,
  input  wire logic [7:0]  summary_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Live one edge after reset, so $past never sees reset-time inputs
  logic live_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) live_r <= 1'b0;
    else live_r <= 1'b1;
  end

  // Category causes and address decode
  wire logic dev_w  = comm_disturbed_i | sensor_mismatch_i | nonvolatile_flag_i;
  wire logic vnd_e  = nvm_timeout_i | checksum_err_i | record_err_i | filament_material_i
                    | atmospheric_pressure_sensor_cfg_i | insulation_config_i | board_config_i
                    | filament_broken_i | diaphragm_broken_i;
  wire logic addr_ok = rec_slot_i == 16'h0000 && rec_subslot_i == 16'h000a;
  wire logic rd_ok   = rec_req_i && !rec_wr_i && addr_ok;

  property p_sum0; live_r |-> summary_o[0] == $past(dev_w); endproperty
  a_sum0: assert property (p_sum0) else $error("summary bit 0 wrong");
  property p_sum1;
    live_r |-> summary_o[1] == $past(atmospheric_pressure_sensor_range_i);
  endproperty
  a_sum1: assert property (p_sum1) else $error("summary bit 1 wrong");
  property p_sum2; live_r |-> summary_o[2] == $past(dev_w); endproperty
  a_sum2: assert property (p_sum2) else $error("summary bit 2 wrong");
  property p_sum3; live_r |-> summary_o[3] == $past(vnd_e); endproperty
  a_sum3: assert property (p_sum3) else $error("summary bit 3 wrong");
  property p_sum_hi; summary_o[7:4] == 4'h0; endproperty
  a_sum_hi: assert property (p_sum_hi) else $error("summary high bits set");
  property p_ack; live_r |-> rec_ack_o == $past(rec_req_i) && (!rec_err_o || rec_ack_o);
  endproperty
  a_ack: assert property (p_ack) else $error("answer timing wrong");
  property p_addr; rec_req_i && !addr_ok |=> rec_err_o && rec_rdata_o == 32'h0;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address not refused");
  property p_wr; rec_req_i && rec_wr_i |=> rec_err_o && rec_rdata_o == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write not refused");
  property p_rd_sum;
    rd_ok && rec_index_i == 16'h0040 |=> !rec_err_o ##0 rec_rdata_o == {24'h0, $past(summary_o)};
  endproperty
  a_rd_sum: assert property (p_rd_sum) else $error("summary read wrong");
  property p_gvw; rd_ok && rec_index_i == 16'h0046 |=> !rec_err_o && rec_rdata_o == 32'h0;
  endproperty
  a_gvw: assert property (p_gvw) else $error("reserved word not zero");

  c_rd: cover property (rd_ok ##1 rec_ack_o && summary_o != 8'h00);
  c_wr: cover property (rec_req_i && rec_wr_i);
  c_all: cover property (summary_o == 8'h0f);
endmodule

bind exsb_bank exsb_bank_chk u_exsb_bank_chk (.*);

/* File: sim/exsb_master.sv */
// Fieldbus master model issuing acyclic record requests one at a time.
// Assumes the bank answers on the taking edge, sampled at the next falling edge.
module exsb_master (
  input  wire logic        ref_clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] rdata_i,
  output logic             req_o,
  output logic             wr_o,
  output logic [15:0]      slot_o,
  output logic [15:0]      subslot_o,
  output logic [15:0]      index_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines start defined
  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    {slot_o, subslot_o, index_o} = 48'h0;
  end

  // One request; released lines go inverse so stale values never match
  task automatic xfer(input logic w, input logic [15:0] s, ss, ix,
                      output logic a, e, output logic [31:0] d);
    @(negedge ref_clk_i);
    req_o = 1'b1;
    wr_o = w;
    {slot_o, subslot_o, index_o} = {s, ss, ix};
    @(negedge ref_clk_i);
    a = ack_i;
    e = err_i;
    d = rdata_i;
    req_o = 1'b0;
    wr_o = ~w;
    {slot_o, subslot_o, index_o} = ~{s, ss, ix};
  endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the exception status bank.
// Assumes the master model and the bound checker are compiled alongside.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Clock, reset, faults and wiring
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [12:0] flt = 13'h0000;
  logic        req, wr, ack, err;
  logic [15:0] slot, sub, idx;
  logic [31:0] rdata;
  logic [7:0]  summary;
  int          errors = 0;
  int          checks_done = 0;
  logic [15:0] ixs [7] = '{16'h0040, 16'h0042, 16'h0044, 16'h0045,
                          16'h0046, 16'h0047, 16'h0048};

  always #2.5 clk = ~clk;

  exsb_bank u_exsb_bank (.ref_clk_i(clk), .arst_n_i(arst_n), .rec_req_i(req), .rec_wr_i(wr),
    .rec_slot_i(slot), .rec_subslot_i(sub), .rec_index_i(idx), .rec_ack_o(ack),
    .rec_err_o(err), .rec_rdata_o(rdata), .comm_disturbed_i(flt[0]),
    .sensor_mismatch_i(flt[1]), .nonvolatile_flag_i(flt[2]), .nvm_timeout_i(flt[3]),
    .checksum_err_i(flt[4]), .record_err_i(flt[5]), .filament_material_i(flt[6]),
    .atmospheric_pressure_sensor_cfg_i(flt[7]), .insulation_config_i(flt[8]),
    .board_config_i(flt[9]),
    .atmospheric_pressure_sensor_range_i(flt[10]), .filament_broken_i(flt[11]),
    .diaphragm_broken_i(flt[12]), .summary_o(summary));

  exsb_master u_exsb_master (.ref_clk_i(clk), .ack_i(ack), .err_i(err), .rdata_i(rdata),
    .req_o(req), .wr_o(wr), .slot_o(slot), .subslot_o(sub), .index_o(idx));

  // ----------------------------------------------------------------
  // Expected words, comparison and access helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_w(input logic [15:0] ix, input logic [12:0] v);
    logic [31:0] gw, ge, vw, ve;
    {gw, ge, vw, ve} = 128'h0;
    gw[1] = v[0] | v[1];
    gw[3] = v[2];
    ge[3:1] = v[5:3];
    ge[5] = v[6];
    ge[11:9] = v[9:7];
    vw[8] = v[10];
    ve[4] = v[11];
    ve[6] = v[12];
    case (ix)
      16'h0040: exp_w = {28'h0, (|ve) || (|ge), |gw, |vw, |gw};
      16'h0042: exp_w = vw;
      16'h0044: exp_w = ve;
      16'h0045, 16'h0047: exp_w = gw;
      16'h0048: exp_w = ge;
      default: exp_w = 32'h0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Writes and bad addresses expect a refusal carrying zero data
  task automatic acc(input logic w, input logic [15:0] s, ss, ix, input logic bad);
    logic        a, e;
    logic [31:0] d;
    u_exsb_master.xfer(w, s, ss, ix, a, e, d);
    chk($sformatf("ack %h", ix), {31'h0, a}, 32'h1);
    chk($sformatf("err %h", ix), {31'h0, e}, {31'h0, bad});
    chk($sformatf("data %h", ix), d, bad ? 32'h0 : exp_w(ix, flt));
  endtask

  task automatic sweep(input logic w);
    for (int i = 0; i < 7; i++) acc(w, 16'h0000, 16'h000a, ixs[i], w);
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the sequence needs well under 2000 cycles
  // ----------------------------------------------------------------
  initial begin
    #50000;
    errors++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    sweep(1'b0);
    // Each fault alone, so a misplaced bit or category shows
    for (int b = 0; b < 13; b++) begin
      @(negedge clk) flt = 13'h0001 << b;
      sweep(1'b0);
      chk("summary", {24'h0, summary}, exp_w(16'h0040, flt));
    end
    @(negedge clk) flt = 13'h1fff;
    sweep(1'b0);
    sweep(1'b1);
    sweep(1'b0);
    acc(1'b0, 16'h0001, 16'h000a, 16'h0040, 1'b1);
    acc(1'b0, 16'h0000, 16'h000b, 16'h0045, 1'b1);
    acc(1'b0, 16'h0000, 16'h000a, 16'h0041, 1'b1);
    acc(1'b0, 16'h0000, 16'h000a, 16'h0043, 1'b1);
    // Mid-run reset clears the summary, then faults reappear
    @(negedge clk) arst_n = 1'b0;
    @(negedge clk) chk("reset summary", {24'h0, summary}, 32'h0);
    arst_n = 1'b1;
    @(negedge clk) flt = 13'h0404;
    sweep(1'b0);
    tally_and_finish;
  end
endmodule
